// ===== rtl/plq_link_status.sv
module plq_link_status import plq_pkg::*; #(
    parameter int GUARD_UNIT_CYCLES = GUARD_UNIT_CYC
) (
    // clock and reset
    input wire logic CLK,
    input wire logic RST_N,
    // ahb-lite slave
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic [31:0] HRDATA,
    output logic HREADYOUT,
    output logic HRESP,
    // receive datapath
    input wire logic RX_MSG_START,
    input wire logic RX_MSG_END,
    input wire logic RX_CARR_VALID,
    input wire logic [6:0] RX_CARR_IDX,
    input wire logic [7:0] RX_CARR_VALUE,
    input wire logic RX_SYM_END,
    input wire logic RX_SYM_HEADER,
    input wire logic [7:0] RX_SYM_STRENGTH,
    input wire logic [15:0] RX_SYM_EVM,
    // transmit datapath
    input wire logic TX_REQ,
    input wire logic TX_BYTE_VALID,
    input wire logic [7:0] TX_BYTE,
    input wire logic TX_LAST,
    input wire logic TX_SAMPLE_VALID,
    input wire logic [7:0] TX_SAMPLE,
    output logic TX_LINE_EN,
    output logic TX_REFUSED,
    output logic [7:0] TX_GAIN,
    // supply sense pins
    input wire logic CURRENT_HIGH,
    input wire logic VOLTAGE_LOW,
    // interrupt
    output logic IRQ
);
    logic [7:0] strength_peak_ff, snr_low_ff, snr_mean_ff, snr_high_ff;
    logic [15:0] hdr_err_ff, pay_err_ff, snr_sum_ff;
    logic [19:0] hdr_sum_ff, pay_sum_ff, carr_acc_ff;
    logic [7:0] sym_cnt_ff, amplitude_ff, gain_ff, guard_ff;
    logic [3:0] sense_ff;
    logic ratio_mode_ff;
    logic [IRQ_W-1:0] irq_stat_ff, irq_mask_ff;
    logic [7:0] ref_tbl [TBL_DEPTH];
    logic [TBL_AW-1:0] load_ptr_ff;
    plq_tx_e tx_state_ff;
    logic [12:0] unit_cnt_ff;
    logic [7:0] guard_units_ff;
    logic cur_s1_ff, cur_s2_ff, volt_s1_ff, volt_s2_ff;
    logic wr_pend_ff;
    logic [15:0] wr_idx_ff;
    logic [31:0] rdata_ff;

    // bus decode; write and read both complete without wait states
    logic take;
    logic [7:0] wbyte;
    assign take = HSEL & HTRANS[1] & HREADY;
    assign wbyte = HWDATA[7:0];
    assign HREADYOUT = 1'b1;
    assign HRESP = 1'b0;
    assign HRDATA = rdata_ff;

    function automatic logic [7:0] sum_byte(input logic [19:0] v, input logic [1:0] sel);
        case (sel)
            2'd0: sum_byte = v[19:12];
            2'd1: sum_byte = v[11:4];
            2'd2: sum_byte = {v[3:0], 4'h0};
            default: sum_byte = 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] rd_byte(input logic [15:0] idx);
        logic [15:0] hs, ps;
        hs = idx - IDX_HDR_SUM;
        ps = idx - IDX_PAY_SUM;
        rd_byte = 8'h00;
        if (idx == IDX_STRENGTH_PEAK) rd_byte = strength_peak_ff;
        else if (idx == IDX_SNR_LOW) rd_byte = snr_low_ff;
        else if (idx == IDX_SNR_MEAN) rd_byte = snr_mean_ff;
        else if (idx == IDX_SNR_HIGH) rd_byte = snr_high_ff;
        else if (idx == IDX_HDR_ERR) rd_byte = hdr_err_ff[15:8];
        else if (idx == IDX_HDR_ERR + 16'h0001) rd_byte = hdr_err_ff[7:0];
        else if (idx == IDX_PAY_ERR) rd_byte = pay_err_ff[15:8];
        else if (idx == IDX_PAY_ERR + 16'h0001) rd_byte = pay_err_ff[7:0];
        else if (hs < 16'h0004) rd_byte = sum_byte(hdr_sum_ff, hs[1:0]);
        else if (ps < 16'h0004) rd_byte = sum_byte(pay_sum_ff, ps[1:0]);
        else if (idx == IDX_AMPLITUDE) rd_byte = amplitude_ff;
        else if (idx == IDX_SENSE_CTRL) rd_byte = {4'h0, sense_ff};
        else if (idx == IDX_PHY_SETUP) rd_byte = {7'h00, ratio_mode_ff};
        else if (idx == IDX_GUARD) rd_byte = guard_ff;
        else if (idx == IDX_IRQ_STATUS) rd_byte = {3'h0, irq_stat_ff};
        else if (idx == IDX_IRQ_MASK) rd_byte = {3'h0, irq_mask_ff};
    endfunction

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            wr_pend_ff <= 1'b0;
            wr_idx_ff <= 16'h0000;
            rdata_ff <= 32'h0000_0000;
        end else begin
            wr_pend_ff <= take & HWRITE;
            wr_idx_ff <= HADDR[17:2];
            if (take & !HWRITE) begin
                rdata_ff <= {24'h000000, rd_byte(HADDR[17:2])};
            end
        end
    end

    logic wr_sense, wr_irq_stat;
    assign wr_sense = wr_pend_ff & (wr_idx_ff == IDX_SENSE_CTRL);
    assign wr_irq_stat = wr_pend_ff & (wr_idx_ff == IDX_IRQ_STATUS);

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            ratio_mode_ff <= 1'b0;
            guard_ff <= RST_GUARD;
            irq_mask_ff <= '0;
        end else if (wr_pend_ff) begin
            if (wr_idx_ff == IDX_PHY_SETUP) ratio_mode_ff <= wbyte[PS_RATIO_MODE];
            if (wr_idx_ff == IDX_GUARD) guard_ff <= wbyte;
            if (wr_idx_ff == IDX_IRQ_MASK) irq_mask_ff <= wbyte[IRQ_W-1:0];
        end
    end

    // supply sense pins come from outside and pass two flops first
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            cur_s1_ff <= 1'b0;
            cur_s2_ff <= 1'b0;
            volt_s1_ff <= 1'b0;
            volt_s2_ff <= 1'b0;
        end else begin
            cur_s1_ff <= CURRENT_HIGH;
            cur_s2_ff <= cur_s1_ff;
            volt_s1_ff <= VOLTAGE_LOW;
            volt_s2_ff <= volt_s1_ff;
        end
    end

    logic emitting, guard_done, sense_cur, sense_volt, pfail_set, vfail_set, fail_any;
    assign emitting = (tx_state_ff == TX_EMIT);
    assign guard_done = (guard_units_ff >= guard_ff);
    assign sense_cur = sense_ff[SC_CONT] | (emitting & guard_done);
    assign sense_volt = sense_ff[SC_ENABLE] & emitting & guard_done;
    assign pfail_set = sense_cur & cur_s2_ff;
    assign vfail_set = sense_volt & volt_s2_ff;
    assign fail_any = sense_ff[SC_PFAIL] | sense_ff[SC_VFAIL];

    // failure flags clear by writing zero; a failure in that cycle still sets
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            sense_ff <= 4'h0;
        end else begin
            if (wr_sense) begin
                sense_ff[SC_ENABLE] <= wbyte[SC_ENABLE];
                sense_ff[SC_CONT] <= wbyte[SC_CONT];
            end
            if (pfail_set) sense_ff[SC_PFAIL] <= 1'b1;
            else if (wr_sense & !wbyte[SC_PFAIL]) sense_ff[SC_PFAIL] <= 1'b0;
            if (vfail_set) sense_ff[SC_VFAIL] <= 1'b1;
            else if (wr_sense & !wbyte[SC_VFAIL]) sense_ff[SC_VFAIL] <= 1'b0;
        end
    end

    // transmit control
    logic req_ok;
    assign req_ok = TX_REQ & !fail_any & !pfail_set & !vfail_set;
    assign TX_REFUSED = TX_REQ & (tx_state_ff == TX_IDLE) & !req_ok;
    assign TX_LINE_EN = emitting;
    assign TX_GAIN = gain_ff;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            tx_state_ff <= TX_IDLE;
            load_ptr_ff <= '0;
        end else begin
            case (tx_state_ff)
                TX_IDLE: begin
                    load_ptr_ff <= '0;
                    if (req_ok & ratio_mode_ff) tx_state_ff <= TX_LOAD;
                    else if (req_ok) tx_state_ff <= TX_EMIT;
                end
                TX_LOAD: begin
                    if (TX_BYTE_VALID) load_ptr_ff <= load_ptr_ff + 1'b1;
                    if (TX_LAST) tx_state_ff <= TX_IDLE;
                end
                TX_EMIT: begin
                    if (pfail_set | vfail_set | TX_LAST) tx_state_ff <= TX_IDLE;
                end
                default: tx_state_ff <= TX_IDLE;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (tx_state_ff == TX_LOAD && TX_BYTE_VALID) ref_tbl[load_ptr_ff] <= TX_BYTE;
    end

    // guard interval counted from the start of each emission
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            unit_cnt_ff <= '0;
            guard_units_ff <= '0;
        end else if (!emitting) begin
            unit_cnt_ff <= '0;
            guard_units_ff <= '0;
        end else if (!guard_done) begin
            if (unit_cnt_ff == 13'(GUARD_UNIT_CYCLES - 1)) begin
                unit_cnt_ff <= '0;
                guard_units_ff <= guard_units_ff + 8'h01;
            end else begin
                unit_cnt_ff <= unit_cnt_ff + 13'h0001;
            end
        end
    end

    // emitted amplitude: peak hold with slow decay; gain nudged once per emission
    logic [7:0] mag;
    assign mag = TX_SAMPLE[7] ? ((TX_SAMPLE == 8'h80) ? 8'h7f : 8'(-TX_SAMPLE)) : TX_SAMPLE;
    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            amplitude_ff <= 8'h00;
            gain_ff <= RST_GAIN;
        end else begin
            if (emitting & TX_SAMPLE_VALID) begin
                if (mag > amplitude_ff) amplitude_ff <= mag;
                else if (amplitude_ff != 8'h00) amplitude_ff <= amplitude_ff - 8'h01;
            end
            if (emitting & TX_LAST) begin
                if (amplitude_ff > AMP_HIGH && gain_ff != 8'h00) gain_ff <= gain_ff - 8'h01;
                else if (amplitude_ff < AMP_LOW && gain_ff != 8'hff) gain_ff <= gain_ff + 8'h01;
            end
        end
    end

    // receive statistics
    logic [7:0] carr_err;
    logic [19:0] sym_sum;
    logic [9:0] noise_q, sig_q;
    logic [7:0] sym_snr;
    logic [7:0] ref_val;
    assign ref_val = ref_tbl[RX_CARR_IDX];
    assign carr_err = (RX_CARR_VALUE > ref_val) ? RX_CARR_VALUE - ref_val : ref_val - RX_CARR_VALUE;
    assign sym_sum = carr_acc_ff + (RX_CARR_VALID ? {12'h000, carr_err} : 20'h00000);

    function automatic logic [4:0] msb_pos(input logic [19:0] v);
        msb_pos = 5'd0;
        for (int i = 0; i < 20; i++) begin
            if (v[i]) msb_pos = 5'(i);
        end
    endfunction

    // six dB of noise per doubling of the error sum; coarse but cheap
    assign noise_q = QDB_PER_BIT * {5'h00, msb_pos(sym_sum)};
    assign sig_q = {2'b00, RX_SYM_STRENGTH};
    assign sym_snr = (sig_q > noise_q) ? 8'(sig_q - noise_q) : 8'h00;

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            carr_acc_ff <= '0;
        end else if (RX_MSG_START | RX_SYM_END) begin
            carr_acc_ff <= '0;
        end else if (RX_CARR_VALID) begin
            carr_acc_ff <= sym_sum;
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            strength_peak_ff <= RST_MAX;
            snr_low_ff <= RST_MIN;
            snr_high_ff <= RST_MAX;
            hdr_err_ff <= '0;
            pay_err_ff <= '0;
            hdr_sum_ff <= '0;
            pay_sum_ff <= '0;
            snr_sum_ff <= '0;
            sym_cnt_ff <= '0;
        end else if (RX_MSG_START) begin
            strength_peak_ff <= RST_MAX;
            snr_low_ff <= RST_MIN;
            snr_high_ff <= RST_MAX;
            hdr_err_ff <= '0;
            pay_err_ff <= '0;
            hdr_sum_ff <= '0;
            pay_sum_ff <= '0;
            snr_sum_ff <= '0;
            sym_cnt_ff <= '0;
        end else if (RX_SYM_END) begin
            if (RX_SYM_STRENGTH > strength_peak_ff) strength_peak_ff <= RX_SYM_STRENGTH;
            if (sym_snr < snr_low_ff) snr_low_ff <= sym_snr;
            if (sym_snr > snr_high_ff) snr_high_ff <= sym_snr;
            // count saturates, so the mean covers the first 255 symbols
            if (sym_cnt_ff != 8'hff) begin
                sym_cnt_ff <= sym_cnt_ff + 8'h01;
                snr_sum_ff <= snr_sum_ff + {8'h00, sym_snr};
            end
            if (RX_SYM_HEADER) begin
                if (RX_SYM_EVM > hdr_err_ff) hdr_err_ff <= RX_SYM_EVM;
                if (sym_sum > hdr_sum_ff) hdr_sum_ff <= sym_sum;
            end else begin
                if (RX_SYM_EVM > pay_err_ff) pay_err_ff <= RX_SYM_EVM;
                if (sym_sum > pay_sum_ff) pay_sum_ff <= sym_sum;
            end
        end
    end

    always_ff @(posedge CLK or negedge RST_N) begin
        if (!RST_N) begin
            snr_mean_ff <= RST_MAX;
        end else if (RX_MSG_END && sym_cnt_ff != 8'h00) begin
            snr_mean_ff <= 8'(snr_sum_ff / {8'h00, sym_cnt_ff});
        end
    end

    // interrupts: set wins over write-one-to-clear
    logic [IRQ_W-1:0] irq_set;
    assign irq_set[IRQ_RX_DONE] = RX_MSG_END;
    assign irq_set[IRQ_PFAIL] = pfail_set;
    assign irq_set[IRQ_VFAIL] = vfail_set;
    assign irq_set[IRQ_REFUSED] = TX_REFUSED;
    assign irq_set[IRQ_LOADED] = (tx_state_ff == TX_LOAD) & TX_LAST;
    generate
        for (genvar g = 0; g < IRQ_W; g++) begin : g_irq
            always_ff @(posedge CLK or negedge RST_N) begin
                if (!RST_N) irq_stat_ff[g] <= 1'b0;
                else if (irq_set[g]) irq_stat_ff[g] <= 1'b1;
                else if (wr_irq_stat & wbyte[g]) irq_stat_ff[g] <= 1'b0;
            end
        end
    endgenerate
    assign IRQ = |(irq_stat_ff & irq_mask_ff);

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RST_N);

    sequence s_clean_sym;
        RX_SYM_END && !RX_MSG_START;
    endsequence
    sequence s_flagged_req;
        TX_REQ && tx_state_ff == TX_IDLE && fail_any;
    endsequence

    strength_peak_a: assert property (s_clean_sym |=>
        strength_peak_ff >= $past(RX_SYM_STRENGTH)) else $error("strength peak missed a symbol");
    snr_low_a: assert property (s_clean_sym |=>
        snr_low_ff <= $past(snr_low_ff) && snr_low_ff <= $past(sym_snr)) else $error("ratio minimum wrong");
    load_divert_a: assert property (tx_state_ff == TX_IDLE && req_ok && ratio_mode_ff |=>
        tx_state_ff == TX_LOAD ##0 !TX_LINE_EN) else $error("beacon not diverted to table");
    hdr_err_a: assert property ((s_clean_sym and RX_SYM_HEADER) |=>
        hdr_err_ff >= $past(RX_SYM_EVM) && pay_err_ff == $past(pay_err_ff)) else $error("header error peak wrong");
    pay_sum_a: assert property ((s_clean_sym and !RX_SYM_HEADER) |=>
        pay_sum_ff >= $past(sym_sum) && hdr_sum_ff == $past(hdr_sum_ff)) else $error("payload sum peak wrong");
    pfail_halt_a: assert property (pfail_set |=>
        sense_ff[SC_PFAIL] && !TX_LINE_EN) else $error("power failure did not halt");
    refuse_tx_a: assert property (s_flagged_req |-> TX_REFUSED ##1 !TX_LINE_EN[*2])
        else $error("transmission started while flagged");
    guard_sense_a: assert property (!sense_ff[SC_CONT] && emitting && !guard_done |->
        !sense_cur) else $error("current sensed inside guard");
    cont_sense_a: assert property (sense_ff[SC_CONT] && cur_s2_ff |=>
        sense_ff[SC_PFAIL]) else $error("continuous sense missed failure");
    vfail_block_a: assert property (vfail_set |=> sense_ff[SC_VFAIL] ##1
        (!TX_LINE_EN || !sense_ff[SC_VFAIL])) else $error("voltage failure did not block");
    reload_a: assert property (RX_MSG_START |=>
        snr_low_ff == RST_MIN && strength_peak_ff == RST_MAX && hdr_sum_ff == 20'h0) else $error("no reload");
endmodule

// ===== include/plq_pkg.sv
// Overview of operation
// - track highest per-symbol signal strength of the last message, quarter-dB byte.
// - expose minimum, mean and maximum per-symbol noise ratio of the last message.
// - noise ratio uses the stored reference beacon table for every later message.
// - in ratio mode a transmit request loads the reference table, nothing emitted.
// - keep header peak error vector, integer percent in 15:9, fraction 8:0.
// - keep payload peak error vector in the same 16-bit layout.
// - keep largest header symbol carrier-error sum, 20 bits.
// - keep largest payload symbol carrier-error sum, 20 bits.
// - read-only byte tracking the amplitude currently emitted on the line.
// - use the emitted amplitude to adjust the emission gain.
// - on supply current failure set the power flag and halt transmission.
// - refuse any new transmission while a failure flag is set.
// - continuous bit low: sense current only in transmission after the guard interval.
// - continuous bit high: sense current always, idle and transmission.
// - on voltage failure set the voltage flag, halt and block transmission.
package plq_pkg;
    // register indices; byte address is four times the index
    localparam logic [15:0] IDX_STRENGTH_PEAK = 16'hfe35;
    localparam logic [15:0] IDX_SNR_LOW = 16'hfe38;
    localparam logic [15:0] IDX_SNR_MEAN = 16'hfe39;
    localparam logic [15:0] IDX_SNR_HIGH = 16'hfe3a;
    localparam logic [15:0] IDX_HDR_ERR = 16'hfe3b;
    localparam logic [15:0] IDX_PAY_ERR = 16'hfe3d;
    localparam logic [15:0] IDX_HDR_SUM = 16'hfe3f;
    localparam logic [15:0] IDX_PAY_SUM = 16'hfe43;
    localparam logic [15:0] IDX_AMPLITUDE = 16'hfe58;
    localparam logic [15:0] IDX_SENSE_CTRL = 16'hfe59;
    localparam logic [15:0] IDX_PHY_SETUP = 16'hfef0;
    localparam logic [15:0] IDX_GUARD = 16'hfef1;
    localparam logic [15:0] IDX_IRQ_STATUS = 16'hfef2;
    localparam logic [15:0] IDX_IRQ_MASK = 16'hfef3;
    // supply_sense_control fields
    localparam int SC_ENABLE = 0;
    localparam int SC_VFAIL = 1;
    localparam int SC_CONT = 2;
    localparam int SC_PFAIL = 3;
    // phy_setup_register field
    localparam int PS_RATIO_MODE = 0;
    // interrupt status fields
    localparam int IRQ_RX_DONE = 0;
    localparam int IRQ_PFAIL = 1;
    localparam int IRQ_VFAIL = 2;
    localparam int IRQ_REFUSED = 3;
    localparam int IRQ_LOADED = 4;
    localparam int IRQ_W = 5;
    // reset values
    localparam logic [7:0] RST_MIN = 8'hff;
    localparam logic [7:0] RST_MAX = 8'h00;
    localparam logic [7:0] RST_GUARD = 8'h2d;
    localparam logic [7:0] RST_GAIN = 8'h80;
    // emission gain targets on the amplitude byte
    localparam logic [7:0] AMP_LOW = 8'h40;
    localparam logic [7:0] AMP_HIGH = 8'h60;
    // reference table
    localparam int TBL_DEPTH = 128;
    localparam int TBL_AW = 7;
    // guard interval unit
    localparam int CLK_PERIOD_NS = 8;
    localparam int GUARD_UNIT_NS = 50000;
    localparam int GUARD_UNIT_CYC = (GUARD_UNIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [9:0] QDB_PER_BIT = 10'h018;
    typedef enum logic [2:0] {
        TX_IDLE = 3'b001,
        TX_LOAD = 3'b010,
        TX_EMIT = 3'b100
    } plq_tx_e;
endpackage

// ===== testbench/plq_medium.sv
module plq_medium (
    // clock
    input wire logic clk,
    // receive datapath toward the block
    output logic msg_start,
    output logic msg_end,
    output logic carr_valid,
    output logic [6:0] carr_idx,
    output logic [7:0] carr_value,
    output logic sym_end,
    output logic sym_header,
    output logic [7:0] sym_strength,
    output logic [15:0] sym_evm
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        {msg_start, msg_end, carr_valid, sym_end, sym_header} = 5'h00;
        {carr_idx, carr_value, sym_strength, sym_evm} = 39'h0;
    end
    task automatic mark(input logic last);
        @(posedge clk);
        msg_start <= !last;
        msg_end <= last;
        @(posedge clk);
        msg_start <= 1'b0;
        msg_end <= 1'b0;
    endtask
    // one carrier then the symbol end; stale fields are inverted so no old value lingers
    task automatic symbol(input logic hdr, input logic [7:0] st, input logic [15:0] evm);
        @(posedge clk);
        carr_valid <= 1'b1;
        carr_idx <= carr_idx + 7'h01;
        carr_value <= 8'h10;
        @(posedge clk);
        carr_valid <= 1'b0;
        carr_value <= 8'hef;
        sym_end <= 1'b1;
        sym_header <= hdr;
        sym_strength <= st;
        sym_evm <= evm;
        @(posedge clk);
        sym_end <= 1'b0;
        sym_header <= !hdr;
        sym_strength <= ~st;
        sym_evm <= ~evm;
    endtask
endmodule

// ===== testbench/plc_link_quality_and_tx_sense_test.sv
`define CHK(nm, ex, got) begin cmp_count++; if ((got) !== (ex)) begin failures++; \
    $display("MISMATCH %s expected %h seen %h", nm, ex, got); end end
module plc_link_quality_and_tx_sense_test import plq_pkg::*; ;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk, rst_n, hsel, hwrite, hreadyout, hresp, tx_req, tx_last, smp_valid, line_en, refused, irq;
    logic cur_high, volt_low, rx_start, rx_end, carr_valid, sym_end, sym_hdr, byte_valid;
    logic [2:0] hsize;
    logic [31:0] haddr, hwdata, hrdata, rdata;
    logic [1:0] htrans;
    logic [6:0] carr_idx;
    logic [7:0] carr_val, sym_str, smp, gain, tx_byte;
    logic [15:0] sym_evm;
    int failures, cmp_count;
    plq_link_status #(.GUARD_UNIT_CYCLES(4)) u_plq_link_status (.CLK(clk), .RST_N(rst_n), .HSEL(hsel),
        .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata), .HREADY(hreadyout),
        .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp), .RX_MSG_START(rx_start), .RX_MSG_END(rx_end),
        .RX_CARR_VALID(carr_valid), .RX_CARR_IDX(carr_idx), .RX_CARR_VALUE(carr_val), .RX_SYM_END(sym_end),
        .RX_SYM_HEADER(sym_hdr), .RX_SYM_STRENGTH(sym_str), .RX_SYM_EVM(sym_evm), .TX_REQ(tx_req),
        .TX_BYTE_VALID(byte_valid), .TX_BYTE(tx_byte), .TX_LAST(tx_last), .TX_SAMPLE_VALID(smp_valid),
        .TX_SAMPLE(smp), .TX_LINE_EN(line_en), .TX_REFUSED(refused), .TX_GAIN(gain), .CURRENT_HIGH(cur_high),
        .VOLTAGE_LOW(volt_low), .IRQ(irq));
    plq_medium u_plq_medium (.clk(clk), .msg_start(rx_start), .msg_end(rx_end), .carr_valid(carr_valid),
        .carr_idx(carr_idx), .carr_value(carr_val), .sym_end(sym_end), .sym_header(sym_hdr),
        .sym_strength(sym_str), .sym_evm(sym_evm));
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // single word transfer; waits on ready with no limit of its own, the watchdog ends a hang
    task automatic bus(input logic wr, input logic [15:0] idx, input logic [7:0] wd);
        @(posedge clk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hsize <= 3'h2;
        hwrite <= wr;
        haddr <= {14'h0, idx, 2'h0};
        do @(posedge clk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h0, wd};
        do @(posedge clk); while (hreadyout !== 1'b1);
        rdata = hrdata;
    endtask
    task automatic rd_chk(input logic [15:0] idx, input logic [7:0] ex, input string nm);
        bus(1'b0, idx, 8'h00);
        `CHK(nm, {24'h0, ex}, rdata)
    endtask
    task automatic tx_req_chk(input logic ex_ref, input logic ex_line);
        @(posedge clk);
        tx_req <= 1'b1;
        #1 `CHK("tx_refused", ex_ref, refused)
        @(posedge clk);
        tx_req <= 1'b0;
        #1 `CHK("tx_line_en", ex_line, line_en)
    endtask
    task automatic tx_end();
        @(posedge clk);
        tx_last <= 1'b1;
        @(posedge clk);
        tx_last <= 1'b0;
        #1 `CHK("tx_line_en", 1'b0, line_en)
    endtask
    // pin held long enough to pass the two-flop synchroniser
    task automatic pin_pulse(input logic volt);
        @(posedge clk);
        if (volt) volt_low <= 1'b1;
        else cur_high <= 1'b1;
        repeat (5) @(posedge clk);
        #1 `CHK("line_after_fail", 1'b0, line_en)
        @(posedge clk);
        {volt_low, cur_high} <= 2'b00;
        repeat (4) @(posedge clk);
    endtask
    task automatic t_reset();
        rd_chk(IDX_STRENGTH_PEAK, RST_MAX, "rx_strength_peak");
        rd_chk(IDX_SNR_LOW, RST_MIN, "snr_low");
        rd_chk(IDX_SNR_HIGH, RST_MAX, "snr_high");
        rd_chk(IDX_AMPLITUDE, 8'h00, "emitted_amplitude");
        rd_chk(IDX_GUARD, RST_GUARD, "guard");
        rd_chk(16'h0100, 8'h00, "unmapped");
        `CHK("hresp_okay", 1'b0, hresp)
        `CHK("tx_gain", RST_GAIN, gain)
    endtask
    task automatic t_rx();
        u_plq_medium.mark(1'b0);
        u_plq_medium.symbol(1'b1, 8'h50, 16'h1234);
        u_plq_medium.symbol(1'b1, 8'h90, 16'h0a00);
        u_plq_medium.symbol(1'b0, 8'h70, 16'h0300);
        u_plq_medium.symbol(1'b0, 8'h60, 16'h2a81);
        u_plq_medium.mark(1'b1);
        // carrier k carries error k against the loaded table; 24 quarter-dB per bit of the sum
        rd_chk(IDX_SNR_LOW, 8'h30, "snr_low_msg");
        rd_chk(IDX_SNR_HIGH, 8'h78, "snr_high_msg");
        rd_chk(IDX_SNR_MEAN, 8'h54, "snr_mean_msg");
        rd_chk(IDX_HDR_SUM + 16'h2, 8'h20, "hdr_sum_lo");
        rd_chk(IDX_PAY_SUM + 16'h2, 8'h40, "pay_sum_lo");
        rd_chk(IDX_STRENGTH_PEAK, 8'h90, "strength_peak");
        rd_chk(IDX_HDR_ERR, 8'h12, "hdr_err_hi");
        rd_chk(IDX_HDR_ERR + 16'h1, 8'h34, "hdr_err_lo");
        rd_chk(IDX_PAY_ERR, 8'h2a, "pay_err_hi");
        rd_chk(IDX_PAY_ERR + 16'h1, 8'h81, "pay_err_lo");
        bus(1'b1, IDX_IRQ_MASK, 8'h01);
        #1 `CHK("irq_rx", 1'b1, irq)
        bus(1'b1, IDX_IRQ_STATUS, 8'h01);
        #1 `CHK("irq_clear", 1'b0, irq)
        bus(1'b1, IDX_IRQ_MASK, 8'h00);
        u_plq_medium.mark(1'b0);
        u_plq_medium.symbol(1'b1, 8'h20, 16'h0001);
        u_plq_medium.mark(1'b1);
        rd_chk(IDX_STRENGTH_PEAK, 8'h20, "strength_reload");
        rd_chk(IDX_HDR_ERR + 16'h1, 8'h01, "hdr_err_reload");
    endtask
    task automatic t_amplitude();
        tx_req_chk(1'b0, 1'b1);
        @(posedge clk);
        smp_valid <= 1'b1;
        smp <= 8'h7f;
        cur_high <= 1'b1;
        @(posedge clk);
        smp_valid <= 1'b0;
        smp <= 8'h80;
        repeat (5) @(posedge clk);
        cur_high <= 1'b0;
        rd_chk(IDX_AMPLITUDE, 8'h7f, "amplitude");
        rd_chk(IDX_SENSE_CTRL, 8'h00, "guarded_sense");
        tx_end();
        `CHK("gain_down", RST_GAIN, gain)
    endtask
    task automatic t_failures();
        bus(1'b1, IDX_SENSE_CTRL, 8'h04);
        pin_pulse(1'b0);
        rd_chk(IDX_SENSE_CTRL, 8'h0c, "idle_sense");
        tx_req_chk(1'b1, 1'b0);
        bus(1'b1, IDX_SENSE_CTRL, 8'h04);
        tx_req_chk(1'b0, 1'b1);
        pin_pulse(1'b0);
        rd_chk(IDX_SENSE_CTRL, 8'h0c, "power_flag");
        bus(1'b1, IDX_SENSE_CTRL, 8'h00);
        bus(1'b1, IDX_GUARD, 8'h00);
        bus(1'b1, IDX_SENSE_CTRL, 8'h01);
        tx_req_chk(1'b0, 1'b1);
        pin_pulse(1'b1);
        rd_chk(IDX_SENSE_CTRL, 8'h03, "voltage_flag");
        tx_req_chk(1'b1, 1'b0);
        bus(1'b1, IDX_SENSE_CTRL, 8'h01);
        rd_chk(IDX_SENSE_CTRL, 8'h01, "voltage_clear");
    endtask
    task automatic t_ratio();
        // software loads the table in ratio mode
        bus(1'b1, IDX_PHY_SETUP, 8'h01);
        tx_req_chk(1'b0, 1'b0);
        // table entry k holds 0x10 + k, while the medium sends 0x10 on carrier k
        for (int i = 0; i < 8; i++) begin
            @(posedge clk);
            byte_valid <= 1'b1;
            tx_byte <= 8'h10 + 8'(i);
        end
        @(posedge clk);
        byte_valid <= 1'b0;
        tx_end();
        bus(1'b1, IDX_IRQ_MASK, 8'h10);
        #1 `CHK("irq_loaded", 1'b1, irq)
        bus(1'b1, IDX_PHY_SETUP, 8'h00);
        tx_req_chk(1'b0, 1'b1);
        tx_end();
        `CHK("gain_up", RST_GAIN + 8'h01, gain)
    endtask
    initial begin
        {rst_n, hsel, hwrite, tx_req, tx_last, smp_valid, cur_high, volt_low, byte_valid} = 9'h000;
        {haddr, hwdata} = 64'h0;
        {htrans, hsize} = 5'h02;
        {smp, tx_byte} = 16'h0000;
        failures = 0;
        cmp_count = 0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        t_reset();
        t_ratio();
        t_rx();
        t_amplitude();
        t_failures();
        stop_test();
    end
    initial begin
        #200us;
        failures++;
        stop_test();
    end
endmodule
